// ===== rtc_alarm_cal.v
// Purpose: Alarm compare, repeat counting and once-a-minute drift trim.
// Assumes: Running time, ticks and sync flag come from logic on clk_sys.
// Notes: Trim pulses leave as one-cycle strobes to the timekeeping counter.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rtc_alarm_defs.vh"

module rtc_alarm_cal (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Running time and ticks
  input  wire [15:0] time_month_day,
  input  wire [15:0] time_weekday_hour,
  input  wire [15:0] time_minute_second,
  input  wire        half_sec_tick,
  input  wire        sec_tick,
  input  wire        minute_tick,
  input  wire        timer_on,
  input  wire        rollover_sync_flag,
  // Alarm and trim outputs
  output reg         alarm_irq,
  output reg         alarm_pulse,
  output reg         trim_add,
  output reg         trim_drop
);

  // ==========================================================================
  // State
  reg        aw_held_q;
  reg [7:0]  aw_addr_q;
  reg        w_held_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg [7:0]  trim_q;
  reg        clock_write_enable_q;
  reg        alarm_enable_q;
  reg        endless_q;
  reg [3:0]  alarm_interval_mask_q;
  reg [1:0]  alarm_window_pointer_q;
  reg [7:0]  alarm_repeat_count_q;
  reg [15:0] alarm_month_day_q;
  reg [15:0] alarm_weekday_hour_q;
  reg [15:0] alarm_minute_second_q;
  reg [9:0]  trim_count_q;
  reg        trim_neg_q;

  wire [15:0] cfg_word;
  wire [15:0] trim_word;
  wire        do_write;
  wire        do_read;
  wire [15:0] wr_merged;
  reg  [7:0]  high_half;
  reg  [7:0]  low_half;
  reg         wr_ok;
  reg         rd_ok;
  reg  [15:0] rd_word;
  reg         match;
  reg         alarm_hit;
  wire [7:0]  trim_mag;
  wire [9:0]  trim_load;
  wire        window_step;

  assign cfg_word  = {alarm_enable_q, endless_q, alarm_interval_mask_q,
                      alarm_window_pointer_q, alarm_repeat_count_q};
  assign trim_word = {6'h00, rollover_sync_flag, clock_write_enable_q, trim_q};

  // ==========================================================================
  // Bus handshakes
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held_q && w_held_q;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  // ==========================================================================
  // Window pointer step on high-half access
  assign window_step   = (do_read && s_axi_araddr == `OFS_WINDOW_HIGH) ||
                         (do_write && aw_addr_q == `OFS_WINDOW_HIGH);

  // ==========================================================================
  // Window halves for the current pointer
  always @* begin
    case (alarm_window_pointer_q)
      `PTR_MIN_SEC: begin
        high_half = alarm_minute_second_q[15:8];
        low_half  = alarm_minute_second_q[7:0];
      end
      `PTR_WEEKDAY_DIGIT_HOUR: begin
        high_half = alarm_weekday_hour_q[15:8];
        low_half  = alarm_weekday_hour_q[7:0];
      end
      `PTR_MONTH_DAY: begin
        high_half = alarm_month_day_q[15:8];
        low_half  = alarm_month_day_q[7:0];
      end
      default: begin
        high_half = 8'h00;
        low_half  = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // Write byte-lane merge against the addressed register
  reg [15:0] wr_old;
  always @* begin
    wr_ok  = 1'b1;
    wr_old = 16'h0000;
    case (aw_addr_q)
      `OFS_TRIM_CTRL:   wr_old = trim_word;
      `OFS_ALARM_CFG:   wr_old = cfg_word;
      `OFS_WINDOW_HIGH: wr_old = {8'h00, high_half};
      `OFS_WINDOW_LOW:  wr_old = {8'h00, low_half};
      default:          wr_ok = 1'b0;
    endcase
  end
  assign wr_merged = {w_strb_q[1] ? w_data_q[15:8] : wr_old[15:8],
                      w_strb_q[0] ? w_data_q[7:0]  : wr_old[7:0]};

  // ==========================================================================
  // Read decode
  always @* begin
    rd_ok   = 1'b1;
    rd_word = 16'h0000;
    case (s_axi_araddr)
      `OFS_TRIM_CTRL:   rd_word = trim_word;
      `OFS_ALARM_CFG:   rd_word = cfg_word;
      `OFS_WINDOW_HIGH: rd_word = {8'h00, high_half};
      `OFS_WINDOW_LOW:  rd_word = {8'h00, low_half};
      default:          rd_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Alarm digit compare
  always @* begin
    case (alarm_interval_mask_q)
      `AM_HALF_SEC: match = 1'b1;
      `AM_SEC:      match = 1'b1;
      `AM_TEN_SEC:  match = time_minute_second[3:0] == alarm_minute_second_q[3:0];
      `AM_MINUTE:   match = time_minute_second[6:0] == alarm_minute_second_q[6:0];
      `AM_TEN_MIN:  match = time_minute_second[11:0] == alarm_minute_second_q[11:0];
      `AM_HOUR:     match = time_minute_second == alarm_minute_second_q;
      `AM_DAY:      match = time_minute_second == alarm_minute_second_q &&
                            time_weekday_hour[5:0] == alarm_weekday_hour_q[5:0];
      `AM_WEEK:     match = time_minute_second == alarm_minute_second_q &&
                            time_weekday_hour == alarm_weekday_hour_q;
      `AM_MONTH:    match = time_minute_second == alarm_minute_second_q &&
                            time_weekday_hour[5:0] == alarm_weekday_hour_q[5:0] &&
                            time_month_day[5:0] == alarm_month_day_q[5:0];
      `AM_YEAR:     match = time_minute_second == alarm_minute_second_q &&
                            time_weekday_hour[5:0] == alarm_weekday_hour_q[5:0] &&
                            time_month_day == alarm_month_day_q;
      default:      match = 1'b0;
    endcase
    if (alarm_interval_mask_q == `AM_HALF_SEC) begin
      alarm_hit = alarm_enable_q && half_sec_tick && match;
    end else begin
      alarm_hit = alarm_enable_q && sec_tick && match;
    end
  end

  // ==========================================================================
  // Trim magnitude and pulse count
  assign trim_mag  = trim_q[7] ? (~trim_q + 8'h01) : trim_q;
  assign trim_load = {2'b00, trim_mag} << `TRIM_SCALE_SHIFT;

  // ==========================================================================
  // Bus channel state
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      aw_held_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word};
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Registers, alarm sequencing and window pointer
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      trim_q                 <= `TRIM_RESET;
      clock_write_enable_q   <= 1'b0;
      alarm_enable_q         <= 1'b0;
      endless_q              <= 1'b0;
      alarm_interval_mask_q  <= 4'h0;
      alarm_window_pointer_q <= 2'b00;
      alarm_repeat_count_q   <= 8'h00;
      alarm_month_day_q      <= 16'h0000;
      alarm_weekday_hour_q   <= 16'h0000;
      alarm_minute_second_q  <= 16'h0000;
      alarm_irq              <= 1'b0;
      alarm_pulse            <= 1'b0;
    end else begin
      alarm_irq <= alarm_hit;
      if (alarm_hit) begin
        alarm_pulse <= ~alarm_pulse;
        if (alarm_repeat_count_q != 8'h00) begin
          alarm_repeat_count_q <= alarm_repeat_count_q - 8'h01;
        end else if (endless_q) begin
          alarm_repeat_count_q <= 8'hff;
        end else begin
          alarm_enable_q <= 1'b0;
        end
      end
      // High-half accesses step the pointer down and stop at zero.
      if (window_step) begin
        if (alarm_window_pointer_q != 2'b00) begin
          alarm_window_pointer_q <= alarm_window_pointer_q - 2'b01;
        end
      end
      if (do_write) begin
        case (aw_addr_q)
          `OFS_TRIM_CTRL: begin
            trim_q               <= wr_merged[7:0];
            clock_write_enable_q <= wr_merged[`TRIM_WREN_BIT];
          end
          `OFS_ALARM_CFG: begin
            alarm_enable_q         <= wr_merged[`CFG_EN_BIT];
            endless_q              <= wr_merged[`CFG_ENDLESS_BIT];
            alarm_interval_mask_q  <= wr_merged[`CFG_MASK_LSB+3:`CFG_MASK_LSB];
            alarm_window_pointer_q <= wr_merged[`CFG_PTR_LSB+1:`CFG_PTR_LSB];
            alarm_repeat_count_q   <= wr_merged[7:0];
          end
          `OFS_WINDOW_HIGH: begin
            case (alarm_window_pointer_q)
              `PTR_MIN_SEC:
                alarm_minute_second_q[15:8] <= wr_merged[7:0] & `MASK_MIN_SEC;
              `PTR_WEEKDAY_DIGIT_HOUR:
                if (clock_write_enable_q) begin
                  alarm_weekday_hour_q[15:8] <= wr_merged[7:0] & `MASK_WEEKDAY;
                end
              `PTR_MONTH_DAY:
                if (clock_write_enable_q) begin
                  alarm_month_day_q[15:8] <= wr_merged[7:0] & `MASK_MONTH;
                end
              default: ;
            endcase
          end
          `OFS_WINDOW_LOW: begin
            case (alarm_window_pointer_q)
              `PTR_MIN_SEC:
                alarm_minute_second_q[7:0] <= wr_merged[7:0] & `MASK_MIN_SEC;
              `PTR_WEEKDAY_DIGIT_HOUR:
                if (clock_write_enable_q) begin
                  alarm_weekday_hour_q[7:0] <= wr_merged[7:0] & `MASK_HOUR;
                end
              `PTR_MONTH_DAY:
                if (clock_write_enable_q) begin
                  alarm_month_day_q[7:0] <= wr_merged[7:0] & `MASK_DAY;
                end
              default: ;
            endcase
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Once-a-minute trim pulse train
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      trim_count_q <= 10'h000;
      trim_neg_q   <= 1'b0;
      trim_add     <= 1'b0;
      trim_drop    <= 1'b0;
    end else begin
      if (minute_tick && timer_on) begin
        trim_count_q <= trim_load;
        trim_neg_q   <= trim_q[7];
        trim_add     <= 1'b0;
        trim_drop    <= 1'b0;
      end else if (trim_count_q != 10'h000) begin
        trim_count_q <= trim_count_q - 10'h001;
        trim_add     <= !trim_neg_q;
        trim_drop    <= trim_neg_q;
      end else begin
        trim_add  <= 1'b0;
        trim_drop <= 1'b0;
      end
    end
  end

endmodule // rtc_alarm_cal

// ===== rtc_alarm_cal_properties.sv
// Purpose: Port-level properties of the alarm and trim block.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Attached by a bind in the testbench top file.
`timescale 1ns/1ps
module rtc_alarm_cal_properties (
  // Clock, reset and bus
  input wire        clk_sys,
  input wire        rst_b,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Ticks, alarm and trim outputs
  input wire        half_sec_tick,
  input wire        sec_tick,
  input wire        minute_tick,
  input wire        alarm_irq,
  input wire        alarm_pulse,
  input wire        trim_add,
  input wire        trim_drop
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Sequences and properties.
  sequence s_tick; half_sec_tick || sec_tick; endsequence
  sequence s_read_wait; s_axi_rvalid && !s_axi_rready; endsequence
  property p_irq_cause; alarm_irq |-> $past(half_sec_tick || sec_tick); endproperty
  property p_pulse_toggle; alarm_irq |-> alarm_pulse != $past(alarm_pulse); endproperty
  property p_pulse_only; $past(rst_b) && alarm_pulse != $past(alarm_pulse) |-> alarm_irq; endproperty
  property p_trim_excl; !(trim_add && trim_drop); endproperty
  property p_trim_run; trim_add && !minute_tick |=> !trim_drop; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_r_hold; s_read_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  // ==========================================================================
  // Assertions.
  a_irq_cause: assert property (p_irq_cause) else $error("alarm irq without a tick");
  a_pulse_toggle: assert property (p_pulse_toggle) else $error("pulse did not toggle");
  a_pulse_only: assert property (p_pulse_only) else $error("pulse moved without alarm");
  a_trim_excl: assert property (p_trim_excl) else $error("add and drop together");
  a_trim_run: assert property (p_trim_run) else $error("trim sign changed mid run");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_r_upper: assert property (p_r_upper) else $error("upper read bits not zero");
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  c_alarm: cover property (s_tick ##1 alarm_irq);
endmodule // rtc_alarm_cal_properties

// ===== rtc_alarm_cal_tb.sv
// Purpose: Self-checking testbench of the alarm and trim block.
// Assumes: AXI4-Lite master driven right after rising edges.
// Notes: Handshakes are sampled mid-cycle, acted on at the next edge.
`timescale 1ns/1ps
`include "rtc_alarm_defs.vh"
module rtc_alarm_cal_tb;
  // ==========================================================================
  // Signals and tables.
  logic        clk_sys, rst_b, awv, wv, bri, arv, rri, hs, st, mt, ton, syn;
  logic [7:0]  awa, ara;
  logic [31:0] wd, got;
  logic [15:0] tmd, twh, tms;
  logic [1:0]  gr;
  logic [3:0]  ws;
  wire         awr, wrd, bv, arr, rv, irq, pls, tadd, tdrp;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  integer      n_fail, comparisons, k, m;
  localparam logic [47:0] base_time = 48'h1231_0623_5959;
  localparam logic [47:0] flip [0:8] = '{48'h0, 48'h1, 48'h10, 48'h100, 48'h1000, 48'h1_0000,
    48'h200_0000, 48'h1_0000_0000, 48'h100_0000_0000};
  localparam logic [15:0] miss [0:8] = '{16'hfc00, 16'hfffc, 16'hfff8, 16'hfff0, 16'hffe0,
    16'hffc0, 16'hfc80, 16'hff00, 16'hfe00};
  localparam logic [7:0] mask_hi [0:2] = '{8'h7f, 8'h07, 8'h1f};
  localparam logic [7:0] mask_lo [0:2] = '{8'h7f, 8'h3f, 8'h3f};

  rtc_alarm_cal u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bri), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rri), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .time_month_day(tmd), .time_weekday_hour(twh), .time_minute_second(tms),
    .half_sec_tick(hs), .sec_tick(st), .minute_tick(mt), .timer_on(ton),
    .rollover_sync_flag(syn), .alarm_irq(irq), .alarm_pulse(pls), .trim_add(tadd), .trim_drop(tdrp));

  // ==========================================================================
  // Shared tasks.
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task conclude;
    $display("checks %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task axw(input logic [7:0] a, input logic [15:0] d);
    logic ha, hw, dn;
    @(posedge clk_sys);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bri <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge clk_sys);
      ha = awv && awr;
      hw = wv && wrd;
      dn = bv;
      gr = br;
      @(posedge clk_sys);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (dn) bri <= 1'b0;
    end
  endtask

  task axr(input logic [7:0] a);
    logic h, dn;
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rri <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge clk_sys);
      h = arv && arr;
      dn = rv;
      got = rd;
      gr = rr;
      @(posedge clk_sys);
      if (h) arv <= 1'b0;
      if (dn) rri <= 1'b0;
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(got, e);
  endtask

  task tick(input logic h, input logic e);
    logic p;
    p = pls;
    @(posedge clk_sys);
    if (h) hs <= 1'b1;
    else st <= 1'b1;
    @(posedge clk_sys);
    hs <= 1'b0;
    st <= 1'b0;
    @(negedge clk_sys);
    chk(irq, e);
    chk(pls, p ^ e);
  endtask

  task trim(input logic [7:0] v, input logic on, input logic [9:0] ea, input logic [9:0] ed);
    integer na, nd;
    axw(8'h00, {8'h00, v});
    @(posedge clk_sys);
    ton <= on;
    mt <= 1'b1;
    @(posedge clk_sys);
    mt <= 1'b0;
    na = 0;
    nd = 0;
    repeat (600) begin
      @(negedge clk_sys);
      na = na + tadd;
      nd = nd + tdrp;
    end
    @(posedge clk_sys);
    ton <= 1'b0;
    chk(na, ea);
    chk(nd, ed);
  endtask

  // ==========================================================================
  // Scenarios.
  task regs_scn;
    rdc(8'h04, 32'h0);
    axr(8'h10);
    chk(gr, `RESP_SLVERR);
    axw(8'h10, 16'hffff);
    chk(gr, `RESP_SLVERR);
    axw(8'h00, 16'h0100);
    ws <= 4'h1;
    axw(8'h00, 16'h0000);
    ws <= 4'h3;
    @(posedge clk_sys);
    syn <= 1'b1;
    rdc(8'h00, 32'h0300);
    @(posedge clk_sys);
    syn <= 1'b0;
    axw(8'h04, 16'h0200);
    for (k = 2; k >= 0; k--) begin
      axw(8'h0c, 16'h00ff);
      axw(8'h08, 16'h00ff);
    end
    axw(8'h04, 16'h0200);
    for (k = 2; k >= 0; k--) begin
      rdc(8'h0c, {24'h0, mask_lo[k]});
      rdc(8'h08, {24'h0, mask_hi[k]});
    end
    rdc(8'h04, 32'h0);
    axw(8'h04, 16'h0300);
    rdc(8'h0c, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h04, 32'h0200);
    axw(8'h00, 16'h0000);
    axw(8'h04, 16'h0200);
    axw(8'h08, 16'h0000);
    chk(gr, `RESP_OKAY);
    axw(8'h0c, 16'h0000);
    axw(8'h08, 16'h0000);
    axw(8'h0c, 16'h00d1);
    axw(8'h04, 16'h0200);
    rdc(8'h08, 32'h1f);
    rdc(8'h0c, 32'h3f);
    axw(8'h04, 16'h0000);
    rdc(8'h0c, 32'h51);
  endtask

  task alarm_scn;
    axw(8'h00, 16'h0100);
    axw(8'h04, 16'h0200);
    for (k = 2; k >= 0; k--) begin
      axw(8'h0c, {8'h00, base_time[k*16 +: 8]});
      axw(8'h08, {8'h00, base_time[k*16+8 +: 8]});
    end
    for (k = 0; k < 9; k++) begin
      axw(8'h04, 16'h0000);
      @(posedge clk_sys);
      {tmd, twh, tms} <= base_time ^ flip[k];
      for (m = 0; m < 16; m++) begin
        axw(8'h04, 16'hc000 | 16'(m << 10));
        tick(m == 0, !miss[k][m]);
      end
    end
    axw(8'h04, 16'h0000);
    @(posedge clk_sys);
    {tmd, twh, tms} <= base_time;
    axw(8'h04, 16'h9801);
    tick(1'b0, 1'b1);
    rdc(8'h04, 32'h9800);
    tick(1'b0, 1'b1);
    rdc(8'h04, 32'h1800);
    tick(1'b0, 1'b0);
    axw(8'h04, 16'h98ff);
    tick(1'b0, 1'b1);
    rdc(8'h04, 32'h98fe);
    axw(8'h04, 16'hd800);
    tick(1'b0, 1'b1);
    rdc(8'h04, 32'hd8ff);
  endtask

  // ==========================================================================
  // Clock, reset, sequence and watchdog.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    conclude;
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    {rst_b, awv, wv, bri, arv, rri, hs, st, mt, ton, syn} = 11'h0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    ws = 4'h3;
    {tmd, twh, tms} = base_time;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(8'h00, 32'h0);
    regs_scn;
    alarm_scn;
    trim(8'h02, 1'b1, 10'd8, 10'd0);
    trim(8'hfe, 1'b1, 10'd0, 10'd8);
    trim(8'h80, 1'b1, 10'd0, 10'd512);
    trim(8'h05, 1'b0, 10'd0, 10'd0);
    conclude;
  end
endmodule // rtc_alarm_cal_tb

bind rtc_alarm_cal rtc_alarm_cal_properties u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .half_sec_tick(half_sec_tick),
  .sec_tick(sec_tick), .minute_tick(minute_tick), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse),
  .trim_add(trim_add), .trim_drop(trim_drop));

// ===== rtc_alarm_defs.vh
// Purpose: Constants for the alarm match and drift trim block of the clock calendar.
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses; alarm values reach software through a pointer window.
//
// How it works
// - Month/day alarm holds month tens bit 12, ones 11:8, day tens 5:4, ones 3:0.
// - Weekday/hour alarm holds weekday 10:8, hour tens 5:4, hour ones 3:0.
// - Minute/second alarm holds minute tens 14:12, ones 11:8, second tens 6:4, ones 3:0.
// - Month/day and weekday/hour alarm writes only land while clock write enable is one.
// - Signed 8-bit trim times four pulses is added or removed once a minute.
// - Negative trim removes pulses, positive trim adds pulses, each minute.
// - Alarm config holds enable 15, endless 14, mask 13:10, repeat count 7:0.
// - Mask picks digits to match: half second, second, seconds digits, minute digits.
// - Masks 0110 to 1001 add hours, weekday, day, month for daily to yearly alarms.
// - Each alarm decrements the repeat count; at zero without endless, enable clears.
// - Count zero gives one alarm; FFh gives up to 255 further repetitions.
// - With endless repeat the count wraps from 00h to FFh and alarms go on.
// - Every alarm event raises the alarm interrupt.
// - Alarm pulse output toggles on each alarm, synchronous to the clock.
// - Two-bit pointer selects the window; high-half access decrements it down to 00.
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

// ==========================================================================
// Register offsets
`define OFS_TRIM_CTRL     8'h00
`define OFS_ALARM_CFG     8'h04
`define OFS_WINDOW_HIGH   8'h08
`define OFS_WINDOW_LOW    8'h0c

// ==========================================================================
// Field positions
`define TRIM_WREN_BIT     8
`define TRIM_SYNC_BIT     9
`define CFG_EN_BIT        15
`define CFG_ENDLESS_BIT   14
`define CFG_MASK_LSB      10
`define CFG_PTR_LSB       8

// ==========================================================================
// Window pointer codes and writable bit masks of each half
`define PTR_MIN_SEC       2'b00
`define PTR_WEEKDAY_DIGIT_HOUR     2'b01
`define PTR_MONTH_DAY     2'b10
`define MASK_MONTH        8'h1f
`define MASK_DAY          8'h3f
`define MASK_WEEKDAY      8'h07
`define MASK_HOUR         8'h3f
`define MASK_MIN_SEC      8'h7f

// ==========================================================================
// Interval mask codes
`define AM_HALF_SEC       4'h0
`define AM_SEC            4'h1
`define AM_TEN_SEC        4'h2
`define AM_MINUTE         4'h3
`define AM_TEN_MIN        4'h4
`define AM_HOUR           4'h5
`define AM_DAY            4'h6
`define AM_WEEK           4'h7
`define AM_MONTH          4'h8
`define AM_YEAR           4'h9

// ==========================================================================
// Reset values, trim scale and bus responses
`define CFG_RESET         16'h0000
`define TRIM_RESET        8'h00
`define TRIM_SCALE_SHIFT  2
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif
